// >>> core/sfhp_map.vh
`ifndef SFHP_MAP_VH
`define SFHP_MAP_VH

// ----------------------------------------
// Lane modes of the data path
// ----------------------------------------
`define SFHP_MODE_W        2
`define SFHP_MODE_SINGLE   2'h0
`define SFHP_MODE_QUAD_IN  2'h1
`define SFHP_MODE_QUAD_OUT 2'h2

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SFHP_BYTE_W        8
`define SFHP_FIFO_DEPTH    8
`define SFHP_PHASE_RST     3'h0
// History resets to an idle low clock and a released pause pin, so no false edge follows reset.
`define SFHP_SYNC_RST      3'h1
`define SFHP_LAST_BIT      3'h7
`define SFHP_LAST_NIB      3'h1
`define SFHP_IDLE_BYTE     8'hff

`endif

// >>> core/sfhp_fifo.v
module sfhp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             rst_b,
	// Write side
	input  wire             wr_valid,
	output wire             wr_ready,
	input  wire [WIDTH-1:0] wr_data,
	// Read side
	output wire             rd_valid,
	input  wire             rd_ready,
	output wire [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wp_reg;
	reg [AW-1:0]    rp_reg;
	reg [AW:0]      cnt_reg;
	wire            do_wr;
	wire            do_rd;

	assign wr_ready = (cnt_reg != DEPTH[AW:0]);
	assign rd_valid = (cnt_reg != {(AW+1){1'b0}});
	assign rd_data  = mem_reg[rp_reg];
	assign do_wr    = wr_valid & wr_ready;
	assign do_rd    = rd_valid & rd_ready;

	function [AW-1:0] bump;
		input [AW-1:0] p;
		begin
			bump = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
		end
	endfunction

	always @(posedge mclk) begin
		if (do_wr) begin
			mem_reg[wp_reg] <= wr_data;
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wp_reg <= bump(wp_reg);
			end
			if (do_rd) begin
				rp_reg <= bump(rp_reg);
			end
			cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end

endmodule

// >>> core/sfhp_core.v
// Summary of operation
// - Pause freezes link state, resumes same point.
// - While paused, clock edges and input ignored.
// - While paused, serial output released.
// - Pause starts only selected, clock low.
// - Self-timed cycle continues through a pause.
// - Quad program samples four lanes rising.
// - Quad read drives four lanes, falling edges.
// - Deselected: outputs released, input ignored.
// - Sample on rising, shift on falling.
`include "sfhp_map.vh"

module sfhp_core #(
	parameter FIFO_DEPTH = `SFHP_FIFO_DEPTH,
	parameter FIFO_AW    = 3
) (
	// Clock and reset
	mclk,
	rst_b,
	// Serial link, sampled in mclk
	cs_b,
	sck,
	pause_b_in,
	data_line_0_in,
	data_line_1_in,
	data_line_2_in,
	// Lane drivers
	data_line_0_out,
	data_line_0_oe,
	data_line_1_out,
	data_line_1_oe,
	data_line_2_out,
	data_line_2_oe,
	data_line_3_out,
	data_line_3_oe,
	// Command side
	lane_mode,
	busy_in,
	// Received bytes
	rx_valid,
	rx_ready,
	rx_data,
	// Bytes to send
	tx_valid,
	tx_ready,
	tx_data,
	// Status
	paused,
	busy_out
);
	input  wire       mclk;
	input  wire       rst_b;
	input  wire       cs_b;
	input  wire       sck;
	input  wire       pause_b_in;
	input  wire       data_line_0_in;
	input  wire       data_line_1_in;
	input  wire       data_line_2_in;
	output reg        data_line_0_out;
	output reg        data_line_0_oe;
	output reg        data_line_1_out;
	output reg        data_line_1_oe;
	output reg        data_line_2_out;
	output reg        data_line_2_oe;
	output reg        data_line_3_out;
	output reg        data_line_3_oe;
	input  wire [1:0] lane_mode;
	input  wire       busy_in;
	output reg        rx_valid;
	input  wire       rx_ready;
	output reg  [7:0] rx_data;
	input  wire       tx_valid;
	output reg        tx_ready;
	input  wire [7:0] tx_data;
	output reg        paused;
	output reg        busy_out;

	// ----------------------------------------
	// Link state
	// ----------------------------------------
	reg [2:0] sck_hist_reg;
	reg [2:0] phase_reg;
	reg [2:0] ophase_reg;
	reg [7:0] got_reg;
	reg [7:0] shin_reg;
	reg [7:0] shout_reg;
	reg       have_out_reg;
	reg       pause_reg;
	reg       pause_next;
	wire      quad;
	wire      rise;
	wire      fall;
	wire      live;
	wire      last_in;
	wire      last_out;
	wire      rx_room;
	wire [7:0] in_byte;
	wire [7:0] shifted;
	wire       fifo_out_valid;
	wire [7:0] fifo_out_data;
	reg        push;

	assign quad = (lane_mode != `SFHP_MODE_SINGLE);
	assign rise = sck_hist_reg[1] & ~sck_hist_reg[2];
	assign fall = ~sck_hist_reg[1] & sck_hist_reg[2];
	assign live = ~cs_b & ~pause_reg;

	// A byte ends after two nibbles in quad lanes and after eight bits otherwise.
	function at_end;
		input [2:0] ph;
		input       nib;
		begin
			at_end = nib ? (ph == `SFHP_LAST_NIB) : (ph == `SFHP_LAST_BIT);
		end
	endfunction

	assign last_in  = at_end(phase_reg, lane_mode == `SFHP_MODE_QUAD_IN);
	assign last_out = at_end(ophase_reg, quad);
	assign shifted  = quad ? {shout_reg[3:0], 4'h0} : {shout_reg[6:0], 1'b0};
	assign rx_room  = ~rx_valid | rx_ready;
	assign in_byte = (lane_mode == `SFHP_MODE_QUAD_IN) ?
		{shin_reg[3:0], sck_hist_reg[0], data_line_2_in, data_line_1_in, data_line_0_in} :
		{shin_reg[6:0], data_line_0_in};

	// Pause may only enter while selected with clock low, and leaves when released.
	always @* begin
		pause_next = pause_reg;
		if (cs_b || quad || pause_b_in) begin
			pause_next = 1'b0;
		end else if (!sck_hist_reg[1]) begin
			pause_next = 1'b1;
		end
	end

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	// In quad input the pause pin carries lane 3, so its sample rides the history
	// bit zero slot; this is safe because the pause is off in quad mode.
	always @(posedge mclk) begin
		if (!rst_b) begin
			sck_hist_reg <= `SFHP_SYNC_RST;
			phase_reg    <= `SFHP_PHASE_RST;
			ophase_reg   <= `SFHP_PHASE_RST;
			shin_reg     <= 8'h00;
			shout_reg    <= 8'h00;
			have_out_reg <= 1'b0;
			pause_reg    <= 1'b0;
			push         <= 1'b0;
			got_reg      <= 8'h00;
			tx_ready     <= 1'b0;
		end else begin
			sck_hist_reg <= {sck_hist_reg[1], sck, pause_b_in};
			pause_reg    <= pause_next;
			push         <= 1'b0;
			tx_ready     <= 1'b0;
			if (cs_b) begin
				phase_reg    <= `SFHP_PHASE_RST;
				ophase_reg   <= `SFHP_PHASE_RST;
				have_out_reg <= 1'b0;
			end else if (live) begin
				// Receive and send keep separate counters, since both run in single lane mode.
				if (rise && lane_mode != `SFHP_MODE_QUAD_OUT) begin
					shin_reg  <= in_byte;
					phase_reg <= last_in ? `SFHP_PHASE_RST : phase_reg + 3'h1;
					if (last_in) begin
						got_reg <= in_byte;
						push    <= 1'b1;
					end
				end
				// Loading on selection puts the first bit out before the first rising edge.
				if (lane_mode != `SFHP_MODE_QUAD_IN) begin
					if (!have_out_reg || (fall && last_out)) begin
						shout_reg    <= tx_valid ? tx_data : `SFHP_IDLE_BYTE;
						have_out_reg <= 1'b1;
						tx_ready     <= tx_valid;
						ophase_reg   <= `SFHP_PHASE_RST;
					end else if (fall) begin
						shout_reg  <= shifted;
						ophase_reg <= ophase_reg + 3'h1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Receive buffer
	// ----------------------------------------
	// A full buffer drops the byte; the link has no way to stall the host clock.
	sfhp_fifo #(
		.WIDTH(`SFHP_BYTE_W),
		.DEPTH(FIFO_DEPTH),
		.AW   (FIFO_AW)
	) u_fifo (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.wr_valid(push),
		.wr_ready(),
		.wr_data (got_reg),
		.rd_valid(fifo_out_valid),
		.rd_ready(rx_room),
		.rd_data (fifo_out_data)
	);

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	wire drive = ~cs_b & ~pause_reg & have_out_reg;

	always @(posedge mclk) begin
		if (!rst_b) begin
			data_line_0_out <= 1'b0;
			data_line_0_oe  <= 1'b0;
			data_line_1_out <= 1'b0;
			data_line_1_oe  <= 1'b0;
			data_line_2_out <= 1'b0;
			data_line_2_oe  <= 1'b0;
			data_line_3_out <= 1'b0;
			data_line_3_oe  <= 1'b0;
			rx_valid        <= 1'b0;
			rx_data         <= 8'h00;
			paused          <= 1'b0;
			busy_out        <= 1'b0;
		end else begin
			// The head byte stands in its own register until the consumer takes it.
			if (fifo_out_valid && rx_room) begin
				rx_valid <= 1'b1;
				rx_data  <= fifo_out_data;
			end else if (rx_ready) begin
				rx_valid <= 1'b0;
			end
			paused   <= pause_reg;
			busy_out <= busy_in;
			if (lane_mode == `SFHP_MODE_QUAD_OUT) begin
				data_line_3_out <= shout_reg[7];
				data_line_2_out <= shout_reg[6];
				data_line_1_out <= shout_reg[5];
				data_line_0_out <= shout_reg[4];
				data_line_3_oe  <= drive;
				data_line_2_oe  <= drive;
				data_line_1_oe  <= drive;
				data_line_0_oe  <= drive;
			end else begin
				data_line_1_out <= shout_reg[7];
				data_line_1_oe  <= drive & ~quad;
				data_line_0_oe  <= 1'b0;
				data_line_2_oe  <= 1'b0;
				data_line_3_oe  <= 1'b0;
			end
		end
	end

endmodule

// >>> dv/sfhp_core_asserts.sv
module sfhp_core_asserts (
	// Watched ports
	input wire       mclk,
	input wire       rst_b,
	input wire       cs_b,
	input wire       pause_b_in,
	input wire [1:0] lane_mode,
	input wire       busy_in,
	input wire       busy_out,
	input wire       paused,
	input wire       rx_valid,
	input wire       rx_ready,
	input wire       data_line_1_oe,
	input wire       data_line_3_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Six cycles cover the pin synchroniser and the output register.
	sequence s_desel; cs_b [*6]; endsequence
	sequence s_pin_quiet; pause_b_in [*6]; endsequence
	sequence s_wait; rx_valid && !rx_ready; endsequence
	chk_pause_released: assert property (paused && $past(paused) |-> !data_line_1_oe)
		else $error("output driven while paused");
	chk_pause_pin: assert property (s_pin_quiet |-> !paused)
		else $error("paused with pin high");
	chk_quad_nopause: assert property ($rose(paused) |-> lane_mode == 2'h0)
		else $error("pause entered in quad mode");
	chk_busy_copy: assert property ($past(rst_b) |-> busy_out == $past(busy_in))
		else $error("busy copy wrong");
	chk_rx_stays: assert property (s_wait |=> rx_valid)
		else $error("byte lost before taken");
	chk_desel_idle: assert property (s_desel |-> !data_line_1_oe && !data_line_3_oe)
		else $error("lane driven while deselected");
	chk_desel_norx: assert property (s_desel |=> !$rose(rx_valid))
		else $error("byte received while deselected");
	chk_lane3_quad: assert property ((lane_mode != 2'h2) [*4] |-> !data_line_3_oe)
		else $error("lane 3 driven outside quad read");
endmodule
bind sfhp_core sfhp_core_asserts chk_u (.*);

// >>> dv/sfhp_host.sv
module sfhp_host (
	output logic       cs_b,
	output logic       sck,
	output logic       hold_b,
	output logic [2:0] dl,
	output logic [7:0] got,
	input  wire  [3:0] dq,
	input  wire        mclk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_b = 1'b1;
		sck = 1'b0;
		hold_b = 1'b1;
		dl = 3'h0;
		got = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// A pause at bit pz wiggles clock and data to prove they are ignored.
	task automatic xfer(input logic [7:0] b, input logic quad, input int pz);
		int n;
		n = quad ? 2 : 8;
		cs_b = 1'b0;
		tick(3);
		for (int i = 0; i < n; i++) begin
			if (i == pz) begin
				hold_b = 1'b0;
				tick(3);
				repeat (2) begin
					sck = ~sck;
					dl = ~dl;
					tick(3);
				end
				hold_b = 1'b1;
				tick(3);
			end
			if (quad) {hold_b, dl} = b[7-4*i -: 4];
			else dl[0] = b[7-i];
			tick(3);
			got = quad ? {got[3:0], dq} : {got[6:0], dq[1]};
			sck = 1'b1;
			tick(3);
			sck = 1'b0;
		end
		tick(3);
		cs_b = 1'b1;
		hold_b = 1'b1;
		dl = ~dl;
	endtask
	task automatic idle_clk();
		repeat (16) begin
			sck = ~sck;
			dl = ~dl;
			tick(3);
		end
	endtask
endmodule

// >>> dv/sfhp_core_test.sv
module sfhp_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	logic       rx_ready = 1'b0;
	logic       tx_valid = 1'b0;
	logic       busy_in = 1'b0;
	logic [1:0] lane_mode = 2'h0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] b;
	logic       seen_p = 1'b0;
	logic       p_d = 1'b0;
	logic       bad3 = 1'b0;
	logic       oe3 = 1'b0;
	logic       seen_t = 1'b0;
	wire        cs_b, sck, hold_b, rx_valid, tx_ready, paused, busy_out;
	wire  [2:0] dl;
	wire  [3:0] dq, oe;
	wire  [7:0] rx_data;
	wire  [7:0] got;
	integer     seed = 32'h906a8ec0;
	int         mismatches = 0;
	int         check_count = 0;
	int         cycles = 0;
	sfhp_host h (.cs_b(cs_b), .sck(sck), .hold_b(hold_b), .dl(dl), .got(got), .dq(dq),
		.mclk(mclk));
	sfhp_core dut_u (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
		.pause_b_in(hold_b), .data_line_0_in(dl[0]), .data_line_1_in(dl[1]),
		.data_line_2_in(dl[2]), .data_line_0_out(dq[0]), .data_line_0_oe(oe[0]),
		.data_line_1_out(dq[1]), .data_line_1_oe(oe[1]), .data_line_2_out(dq[2]),
		.data_line_2_oe(oe[2]), .data_line_3_out(dq[3]), .data_line_3_oe(oe[3]),
		.lane_mode(lane_mode), .busy_in(busy_in), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .paused(paused), .busy_out(busy_out));
	initial forever #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		p_d <= paused;
		if (paused) seen_p <= 1'b1;
		if (paused && p_d && oe[1]) bad3 <= 1'b1;
		if (oe[3]) oe3 <= 1'b1;
		if (tx_ready) seen_t <= 1'b1;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic take(input logic [7:0] exp);
		int t;
		t = 0;
		while (rx_valid !== 1'b1 && t < 400) begin
			@(negedge mclk);
			t++;
		end
		@(negedge mclk);
		check(rx_data, exp);
		rx_ready = 1'b1;
		@(negedge mclk);
		rx_ready = 1'b0;
		@(negedge mclk);
	endtask
	// With nothing queued to send, the link shows the idle byte.
	function automatic logic [7:0] exp_out(input logic v, input logic [7:0] d);
		return v ? d : 8'hff;
	endfunction
	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge mclk);
		rst_b = 1'b1;
		for (int k = 0; k < 6; k++) begin
			b = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($random(seed));
			h.xfer(b, 1'b0, -1);
			check(got, exp_out(tx_valid, tx_data));
			take(b);
		end
		busy_in = 1'b1;
		tx_valid = 1'b1;
		tx_data = 8'($random(seed));
		b = 8'($random(seed));
		h.xfer(b, 1'b0, 3);
		check(got, exp_out(tx_valid, tx_data));
		tx_valid = 1'b0;
		take(b);
		check({7'h0, seen_p}, 8'h01);
		check({7'h0, bad3}, 8'h00);
		check({7'h0, busy_out}, 8'h01);
		h.idle_clk();
		check({7'h0, rx_valid}, 8'h00);
		lane_mode = 2'h1;
		b = 8'($random(seed));
		h.xfer(b, 1'b1, -1);
		take(b);
		lane_mode = 2'h2;
		tx_valid = 1'b1;
		tx_data = 8'($random(seed));
		h.xfer(8'h00, 1'b1, -1);
		check(got, exp_out(tx_valid, tx_data));
		check({7'h0, oe3}, 8'h01);
		check({7'h0, seen_t}, 8'h01);
		print_verdict();
	end
endmodule
